// ==== design/fbod_pkg.sv ====
// constants and types shared by the opcode decoder and its arithmetic unit
package fbod_pkg;
    // ******************************
    // special register addresses
    // ******************************
    localparam logic [6:0] ADDR_TIMER = 7'h01;
    localparam logic [6:0] ADDR_PCL = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam logic [6:0] ADDR_PORT = 7'h06;
    localparam logic [6:0] ADDR_DIR = 7'h05;
    // ******************************
    // status and direction bit positions
    // ******************************
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int DIR_INPUT_ONLY_BIT = 3;
    localparam logic [7:0] DIR_FORCE_MASK = 8'h08;
    // ******************************
    // widths and reset values
    // ******************************
    localparam int PC_W = 13;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [7:0] W_RESET = 8'h00;
    // ******************************
    // class codes and sub-opcodes
    // ******************************
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUBTRACT_W_FROM_REG = 4'h2;
    localparam logic [3:0] OP_DECREMENT_REG = 4'h3;
    localparam logic [3:0] OP_OR_W_REG = 4'h4;
    localparam logic [3:0] OP_AND_W_REG = 4'h5;
    localparam logic [3:0] OP_XOR_W_REG = 4'h6;
    localparam logic [3:0] OP_ADD_W_REG = 4'h7;
    localparam logic [3:0] OP_MOVE_REG = 4'h8;
    localparam logic [3:0] OP_COMPLEMENT_REG = 4'h9;
    localparam logic [3:0] OP_INCREMENT_REG = 4'hA;
    localparam logic [3:0] OP_DECREMENT_SKIP_ZERO = 4'hB;
    localparam logic [3:0] OP_RRF = 4'hC;
    localparam logic [3:0] OP_RLF = 4'hD;
    localparam logic [3:0] OP_SWAP_NIBBLES = 4'hE;
    localparam logic [3:0] OP_INCREMENT_SKIP_ZERO = 4'hF;
    localparam logic [1:0] BOP_CLEAR = 2'h0;
    localparam logic [1:0] BOP_SET = 2'h1;
    localparam logic [1:0] BOP_SKIP_CLEAR = 2'h2;
    localparam logic [1:0] BOP_SKIP_SET = 2'h3;
    localparam logic [7:0] MISC_RETURN = 8'h08;
    localparam logic [7:0] MISC_INT_RETURN = 8'h09;
    localparam logic [7:0] MISC_STANDBY = 8'h63;
    localparam logic [7:0] MISC_WDT_CLEAR = 8'h64;

    typedef enum logic [3:0] {
        FBOD_PASS, FBOD_ADD, FBOD_SUB, FBOD_AND, FBOD_OR, FBOD_XOR, FBOD_INC,
        FBOD_DEC, FBOD_COM, FBOD_RLC, FBOD_RRC, FBOD_SWAP, FBOD_BCLR, FBOD_BSET,
        FBOD_ZERO, FBOD_WPASS
    } fbod_alu_e;

    typedef enum logic {FBOD_EXEC, FBOD_FLUSH} fbod_state_e;
endpackage

// ==== design/fbod_alu.sv ====
// arithmetic and logic unit of the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module fbod_alu (
    input wire fbod_pkg::fbod_alu_e op,
    input wire logic [7:0] a,
    input wire logic [7:0] w,
    input wire logic c_in,
    input wire logic [2:0] bit_sel,
    output logic [7:0] y,
    output logic c_out,
    output logic dc_out
);
    logic [8:0] sum;
    logic [4:0] half;

    always_comb begin
        sum = 9'h000;
        half = 5'h00;
        y = a;
        c_out = c_in;
        dc_out = 1'b0;
        unique case (op)
            fbod_pkg::FBOD_PASS: y = a;
            fbod_pkg::FBOD_WPASS: y = w;
            fbod_pkg::FBOD_ZERO: y = 8'h00;
            fbod_pkg::FBOD_ADD: begin
                sum = {1'b0, a} + {1'b0, w};
                half = {1'b0, a[3:0]} + {1'b0, w[3:0]};
                y = sum[7:0];
                c_out = sum[8];
                dc_out = half[4];
            end
            // carry means no borrow
            fbod_pkg::FBOD_SUB: begin
                sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
                half = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                y = sum[7:0];
                c_out = sum[8];
                dc_out = half[4];
            end
            fbod_pkg::FBOD_AND: y = a & w;
            fbod_pkg::FBOD_OR: y = a | w;
            fbod_pkg::FBOD_XOR: y = a ^ w;
            fbod_pkg::FBOD_INC: y = a + 8'h01;
            fbod_pkg::FBOD_DEC: y = a - 8'h01;
            fbod_pkg::FBOD_COM: y = ~a;
            fbod_pkg::FBOD_RLC: begin
                y = {a[6:0], c_in};
                c_out = a[7];
            end
            fbod_pkg::FBOD_RRC: begin
                y = {c_in, a[7:1]};
                c_out = a[0];
            end
            fbod_pkg::FBOD_SWAP: y = {a[3:0], a[7:4]};
            fbod_pkg::FBOD_BCLR: y = a & ~(8'h01 << bit_sel);
            fbod_pkg::FBOD_BSET: y = a | (8'h01 << bit_sel);
        endcase
    end
endmodule
`default_nettype wire

// ==== design/fbod_decoder.sv ====
// 14-bit opcode decoder and executor with special register handling
// Operation
// - direction register bit 3 always reads one, also inside read-modify-write.
// - program counter high byte not addressable; low byte read gives only low byte.
// - writing pc low byte loads it and copies holding latch into high byte.
// - modify of pc low byte uses old low byte, latch to high, result to low.
// - bit set and clear read whole register, change one bit, write byte back.
// - port register used as its own source reads the pin levels.
// - writing the timer register clears the prescaler when assigned to the timer.
// - pc change or true skip takes two cycles, second one a no-operation.
// - byte add, subtract set C, DC, Z; and, or, xor set Z only.
// - inc, dec, complement, move set Z; skip forms change no flags, skip on zero.
// - rotates through carry affect only carry; nibble swap affects no flag.
// - bit clear, set, test-skip-clear, test-skip-set alter no status flags.
// - literal add, subtract set C, DC, Z; logic ops set Z; load sets nothing.
// - call, jump, return, interrupt return, return with literal take two cycles.
// - watchdog clear and standby entry are single cycle and set timeout; watchdog clear sets powerdown, standby entry clears it.
// - byte result goes to W when destination bit is zero, else to register.
// - flag updates override bits written into the status register.
`timescale 1ns/1ps
`default_nettype none
module fbod_decoder #(
    parameter int PC_WIDTH = fbod_pkg::PC_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] port_pins,
    input wire logic [4:0] pc_high_holding_latch,
    input wire logic [PC_WIDTH-1:0] stack_top,
    input wire logic prescaler_on_timer,
    output logic [6:0] file_raddr,
    output logic nop_cycle,
    output logic file_we,
    output logic [6:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic [7:0] w_reg,
    output logic [4:0] status_flags,
    output logic [PC_WIDTH-1:0] pc,
    output logic stack_push,
    output logic [PC_WIDTH-1:0] stack_wdata,
    output logic stack_pop,
    output logic interrupt_enable_set,
    output logic prescaler_clear,
    output logic watchdog_clear,
    output logic standby_enter
);
    // ******************************
    // pin synchroniser
    // ******************************
    logic [7:0] pins_meta;
    logic [7:0] pins_sync;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pins_meta <= 8'h00;
            pins_sync <= 8'h00;
        end else begin
            pins_meta <= port_pins;
            pins_sync <= pins_meta;
        end
    end

    // ******************************
    // operand fetch
    // ******************************
    fbod_pkg::fbod_state_e state, next_state;
    logic flush_adv, next_flush_adv;
    logic [7:0] next_w;
    logic [4:0] flags, next_flags;
    logic [PC_WIDTH-1:0] next_pc, next_stack_wdata;
    logic next_file_we, next_stack_push, next_stack_pop, next_ie_set;
    logic next_psc_clear, next_wdt_clear, next_standby;
    logic [6:0] next_file_waddr;
    logic [7:0] next_file_wdata;

    logic [1:0] cls;
    logic [3:0] op4;
    logic dbit;
    logic [6:0] faddr;
    logic [7:0] lit;
    logic [7:0] operand;
    assign cls = instr[13:12];
    assign op4 = instr[11:8];
    assign dbit = instr[7];
    assign faddr = instr[6:0];
    assign lit = instr[7:0];
    assign file_raddr = faddr;
    assign nop_cycle = (state == fbod_pkg::FBOD_FLUSH);

    function automatic logic [7:0] read_operand(input logic [6:0] addr,
                                                input logic [7:0] rd);
        logic [7:0] v;
        v = rd;
        if (addr == fbod_pkg::ADDR_PORT) v = pins_sync;
        if (addr == fbod_pkg::ADDR_DIR) v = rd | fbod_pkg::DIR_FORCE_MASK;
        if (addr == fbod_pkg::ADDR_PCL) v = pc[7:0];
        if (addr == fbod_pkg::ADDR_STATUS) v = {rd[7:5], flags};
        return v;
    endfunction

    assign operand = read_operand(faddr, file_rdata);

    // ******************************
    // decode
    // ******************************
    fbod_pkg::fbod_alu_e alu_op;
    logic use_lit, to_w, to_f, aff_z, aff_c, aff_dc, skip_zero, skip_bit;
    logic [7:0] alu_y;
    logic alu_c, alu_dc, bit_val;
    assign bit_val = operand[instr[9:7]];

    always_comb begin
        alu_op = fbod_pkg::FBOD_PASS;
        use_lit = 1'b0;
        to_w = 1'b0;
        to_f = 1'b0;
        aff_z = 1'b0;
        aff_c = 1'b0;
        aff_dc = 1'b0;
        skip_zero = 1'b0;
        skip_bit = 1'b0;
        unique case (cls)
            fbod_pkg::CLS_BYTE: begin
                to_w = !dbit;
                to_f = dbit;
                unique case (op4)
                    fbod_pkg::OP_MISC: begin
                        alu_op = fbod_pkg::FBOD_WPASS;
                        to_w = 1'b0;
                    end
                    fbod_pkg::OP_CLR: begin
                        alu_op = fbod_pkg::FBOD_ZERO;
                        aff_z = 1'b1;
                    end
                    fbod_pkg::OP_ADD_W_REG, fbod_pkg::OP_SUBTRACT_W_FROM_REG: begin
                        alu_op = (op4 == fbod_pkg::OP_ADD_W_REG) ? fbod_pkg::FBOD_ADD
                                                            : fbod_pkg::FBOD_SUB;
                        {aff_z, aff_c, aff_dc} = 3'h7;
                    end
                    fbod_pkg::OP_AND_W_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_AND, 1'b1};
                    fbod_pkg::OP_OR_W_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_OR, 1'b1};
                    fbod_pkg::OP_XOR_W_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_XOR, 1'b1};
                    fbod_pkg::OP_INCREMENT_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_INC, 1'b1};
                    fbod_pkg::OP_DECREMENT_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_DEC, 1'b1};
                    fbod_pkg::OP_COMPLEMENT_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_COM, 1'b1};
                    fbod_pkg::OP_MOVE_REG: {alu_op, aff_z} = {fbod_pkg::FBOD_PASS, 1'b1};
                    fbod_pkg::OP_INCREMENT_SKIP_ZERO: {alu_op, skip_zero} = {fbod_pkg::FBOD_INC, 1'b1};
                    fbod_pkg::OP_DECREMENT_SKIP_ZERO: {alu_op, skip_zero} = {fbod_pkg::FBOD_DEC, 1'b1};
                    fbod_pkg::OP_RLF: {alu_op, aff_c} = {fbod_pkg::FBOD_RLC, 1'b1};
                    fbod_pkg::OP_RRF: {alu_op, aff_c} = {fbod_pkg::FBOD_RRC, 1'b1};
                    fbod_pkg::OP_SWAP_NIBBLES: alu_op = fbod_pkg::FBOD_SWAP;
                endcase
            end
            fbod_pkg::CLS_BIT: begin
                unique case (op4[3:2])
                    fbod_pkg::BOP_CLEAR: {alu_op, to_f} = {fbod_pkg::FBOD_BCLR, 1'b1};
                    fbod_pkg::BOP_SET: {alu_op, to_f} = {fbod_pkg::FBOD_BSET, 1'b1};
                    fbod_pkg::BOP_SKIP_CLEAR: skip_bit = !bit_val;
                    fbod_pkg::BOP_SKIP_SET: skip_bit = bit_val;
                endcase
            end
            fbod_pkg::CLS_JUMP: alu_op = fbod_pkg::FBOD_PASS;
            fbod_pkg::CLS_LIT: begin
                use_lit = 1'b1;
                to_w = 1'b1;
                if (op4[3:1] == 3'h7 || op4[3:1] == 3'h6) begin
                    alu_op = (op4[3:1] == 3'h7) ? fbod_pkg::FBOD_ADD : fbod_pkg::FBOD_SUB;
                    {aff_z, aff_c, aff_dc} = 3'h7;
                end else if (op4 == 4'h9) begin
                    {alu_op, aff_z} = {fbod_pkg::FBOD_AND, 1'b1};
                end else if (op4 == 4'h8) begin
                    {alu_op, aff_z} = {fbod_pkg::FBOD_OR, 1'b1};
                end else if (op4 == 4'hA) begin
                    {alu_op, aff_z} = {fbod_pkg::FBOD_XOR, 1'b1};
                end else if (op4[3:2] == 2'h0 || op4[3:2] == 2'h1) begin
                    alu_op = fbod_pkg::FBOD_PASS;
                end else begin
                    to_w = 1'b0;
                end
            end
        endcase
    end

    // bit ops modify the whole byte
    fbod_alu u_alu (
        .op(alu_op),
        .a(use_lit ? lit : operand),
        .w(w_reg),
        .c_in(flags[fbod_pkg::ST_C]),
        .bit_sel(instr[9:7]),
        .y(alu_y),
        .c_out(alu_c),
        .dc_out(alu_dc)
    );

    // ******************************
    // execute
    // ******************************
    always_comb begin
        next_state = fbod_pkg::FBOD_EXEC;
        next_flush_adv = 1'b0;
        next_w = w_reg;
        next_flags = flags;
        next_pc = pc;
        next_file_we = 1'b0;
        next_file_waddr = faddr;
        next_file_wdata = alu_y;
        next_stack_push = 1'b0;
        next_stack_pop = 1'b0;
        next_stack_wdata = stack_wdata;
        next_ie_set = 1'b0;
        next_psc_clear = 1'b0;
        next_wdt_clear = 1'b0;
        next_standby = 1'b0;
        if (state == fbod_pkg::FBOD_FLUSH) begin
            if (flush_adv) next_pc = pc + 1'b1;
        end else if (instr_valid) begin
            next_pc = pc + 1'b1;
            if (to_w) next_w = alu_y;
            if (to_f) begin
                if (faddr == fbod_pkg::ADDR_PCL) begin
                    // latch to high, value to low
                    next_pc = PC_WIDTH'({pc_high_holding_latch, alu_y});
                    next_state = fbod_pkg::FBOD_FLUSH;
                end else if (faddr == fbod_pkg::ADDR_STATUS) begin
                    next_flags[2:0] = alu_y[2:0];
                end else begin
                    next_file_we = 1'b1;
                end
                if (faddr == fbod_pkg::ADDR_TIMER && prescaler_on_timer) begin
                    next_psc_clear = 1'b1;
                end
            end
            // computed flags win over written bits
            if (aff_z) next_flags[fbod_pkg::ST_Z] = (alu_y == 8'h00);
            if (aff_c) next_flags[fbod_pkg::ST_C] = alu_c;
            if (aff_dc) next_flags[fbod_pkg::ST_DC] = alu_dc;
            // true skip costs a flush cycle
            if ((skip_zero && alu_y == 8'h00) || skip_bit) begin
                next_state = fbod_pkg::FBOD_FLUSH;
                next_flush_adv = 1'b1;
            end
            if (cls == fbod_pkg::CLS_JUMP) begin
                next_pc = PC_WIDTH'({pc_high_holding_latch[4:3], instr[10:0]});
                next_state = fbod_pkg::FBOD_FLUSH;
                if (!instr[11]) begin
                    next_stack_push = 1'b1;
                    next_stack_wdata = pc + 1'b1;
                end
            end
            if ((cls == fbod_pkg::CLS_LIT && op4[3:2] == 2'h1) ||
                (cls == fbod_pkg::CLS_BYTE && op4 == fbod_pkg::OP_MISC && !dbit &&
                 (lit == fbod_pkg::MISC_RETURN || lit == fbod_pkg::MISC_INT_RETURN))) begin
                next_pc = stack_top;
                next_stack_pop = 1'b1;
                next_state = fbod_pkg::FBOD_FLUSH;
                next_ie_set = (cls == fbod_pkg::CLS_BYTE && lit[0]);
            end
            if (cls == fbod_pkg::CLS_BYTE && op4 == fbod_pkg::OP_MISC && !dbit) begin
                if (lit == fbod_pkg::MISC_WDT_CLEAR) begin
                    next_wdt_clear = 1'b1;
                    next_flags[fbod_pkg::ST_TO] = 1'b1;
                    next_flags[fbod_pkg::ST_PD] = 1'b1;
                end else if (lit == fbod_pkg::MISC_STANDBY) begin
                    next_standby = 1'b1;
                    next_flags[fbod_pkg::ST_TO] = 1'b1;
                    next_flags[fbod_pkg::ST_PD] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= fbod_pkg::FBOD_EXEC;
            flush_adv <= 1'b0;
            w_reg <= fbod_pkg::W_RESET;
            flags <= 5'h18;
            pc <= PC_WIDTH'(fbod_pkg::PC_RESET);
            file_we <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
            stack_push <= 1'b0;
            stack_pop <= 1'b0;
            stack_wdata <= '0;
            interrupt_enable_set <= 1'b0;
            prescaler_clear <= 1'b0;
            watchdog_clear <= 1'b0;
            standby_enter <= 1'b0;
        end else begin
            state <= next_state;
            flush_adv <= next_flush_adv;
            w_reg <= next_w;
            flags <= next_flags;
            pc <= next_pc;
            file_we <= next_file_we;
            file_waddr <= next_file_waddr;
            file_wdata <= next_file_wdata;
            stack_push <= next_stack_push;
            stack_pop <= next_stack_pop;
            stack_wdata <= next_stack_wdata;
            interrupt_enable_set <= next_ie_set;
            prescaler_clear <= next_psc_clear;
            watchdog_clear <= next_wdt_clear;
            standby_enter <= next_standby;
        end
    end
    assign status_flags = flags;
endmodule
`default_nettype wire

// ==== verif/fbod_file_model.sv ====
// file register space model answering the decoder's reads and writes
`timescale 1ns/1ps
`default_nettype none
module fbod_file_model (
    input wire logic clk,
    input wire logic [6:0] file_raddr,
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    output logic [7:0] file_rdata
);
    // ******************************
    // storage
    // ******************************
    logic [7:0] mem [128];
    // each location starts as its address plus 0x10
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) + 8'h10;
        end
    end
    always @(posedge clk) begin
        if (file_we) begin
            mem[file_waddr] <= file_wdata;
        end
    end
    assign file_rdata = mem[file_raddr];
endmodule
`default_nettype wire

// ==== verif/fbod_decoder_monitor.sv ====
// concurrent checks on the opcode decoder ports
`timescale 1ns/1ps
`default_nettype none
module fbod_decoder_monitor #(
    parameter int PC_WIDTH = fbod_pkg::PC_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic [7:0] file_rdata,
    input wire logic [4:0] pc_high_holding_latch,
    input wire logic [PC_WIDTH-1:0] stack_top,
    input wire logic prescaler_on_timer,
    input wire logic nop_cycle,
    input wire logic file_we,
    input wire logic [6:0] file_waddr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] w_reg,
    input wire logic [4:0] status_flags,
    input wire logic [PC_WIDTH-1:0] pc,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic prescaler_clear,
    input wire logic watchdog_clear,
    input wire logic standby_enter
);
    // ******************************
    // properties
    // ******************************
    logic taken;
    assign taken = instr_valid && !nop_cycle;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_jump;
        taken && instr[13:11] == 3'b101 |=> nop_cycle && pc[10:0] == $past(instr[10:0])
            && pc[12:11] == $past(pc_high_holding_latch[4:3]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or flush wrong");
    property p_call;
        taken && instr[13:11] == 3'b100 |=> stack_push && nop_cycle;
    endproperty
    a_call: assert property (p_call) else $error("call without push");
    property p_ret;
        taken && instr == 14'h0008 |=> stack_pop && nop_cycle && pc == $past(stack_top);
    endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_pcl_write;
        taken && instr[13:7] == 7'h01 && instr[6:0] == fbod_pkg::ADDR_PCL |=> nop_cycle
            && !file_we && pc == {$past(pc_high_holding_latch), $past(w_reg)};
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("pc low write wrong");
    property p_flush;
        nop_cycle |=> !file_we && !stack_push && !stack_pop;
    endproperty
    a_flush: assert property (p_flush) else $error("flushed word executed");
    property p_bit_flags;
        taken && instr[13:12] == 2'b01 && instr[6:0] != fbod_pkg::ADDR_STATUS
            |=> $stable(status_flags);
    endproperty
    a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags");
    property p_bit_set;
        taken && instr[13:10] == 4'b0101 && (instr[6:0] == 7'h04 || instr[6:0] > 7'h06)
            |=> file_we && file_waddr == $past(instr[6:0])
            && file_wdata == ($past(file_rdata) | (8'h01 << $past(instr[9:7])));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set not whole byte");
    property p_dir_bit;
        taken && instr[13:10] == 4'b0100 && instr[6:0] == fbod_pkg::ADDR_DIR && instr[9:7] != 3'h3
            |=> file_we && file_wdata[3];
    endproperty
    a_dir_bit: assert property (p_dir_bit) else $error("direction bit 3 lost");
    property p_timer;
        taken && instr[13:12] == 2'b00 && instr[7] && instr[6:0] == fbod_pkg::ADDR_TIMER
            |=> prescaler_clear == $past(prescaler_on_timer);
    endproperty
    a_timer: assert property (p_timer) else $error("prescaler clear wrong");
    property p_sleep;
        taken && instr == 14'h0063 |=> standby_enter && !nop_cycle && status_flags[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep) else $error("standby entry wrong");
    property p_wdt;
        taken && instr == 14'h0064 |=> watchdog_clear && !nop_cycle && status_flags[4:3] == 2'b11;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
    c_jump: cover property (taken && instr[13:11] == 3'b101);
    c_skip: cover property (taken && instr[13:8] == 6'h0F ##1 nop_cycle);
    c_bit_set: cover property (taken && instr[13:10] == 4'b0101);
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking testbench of the opcode decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ******************************
    // stimulus and checks
    // ******************************
    localparam int PC_WIDTH = 13;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic instr_valid = 1'b0;
    logic [7:0] port_pins = 8'hC3;
    logic [4:0] pc_high_holding_latch = 5'h15;
    logic [12:0] stack_top = 13'h0ABC;
    logic prescaler_on_timer = 1'b0;
    logic [7:0] file_rdata, file_wdata, w_reg;
    logic [6:0] file_raddr, file_waddr;
    logic [4:0] status_flags;
    logic [12:0] pc, stack_wdata;
    logic nop_cycle, file_we, stack_push, stack_pop, interrupt_enable_set;
    logic prescaler_clear, watchdog_clear, standby_enter;
    int failures = 0;
    int check_count = 0;
    logic [13:0] lw [12] = '{14'h3010, 14'h3EF0, 14'h3008, 14'h3E08, 14'h3C10, 14'h30A3,
        14'h395F, 14'h3830, 14'h3A33, 14'h3001, 14'h3C00, 14'h3B55};
    logic [7:0] ew [12] = '{8'h10, 8'h00, 8'h08, 8'h10, 8'h00, 8'hA3, 8'h03, 8'h33, 8'h00,
        8'h01, 8'hFF, 8'hFF};
    logic [4:0] ef [12] = '{5'h18, 5'h1D, 5'h1D, 5'h1A, 5'h1F, 5'h1F, 5'h1B, 5'h1B, 5'h1F,
        5'h1F, 5'h18, 5'h18};
    always #4 clk = ~clk;
    fbod_decoder #(.PC_WIDTH(PC_WIDTH)) DUT (.clk(clk), .resetn(resetn), .instr(instr),
        .instr_valid(instr_valid), .file_rdata(file_rdata), .port_pins(port_pins),
        .pc_high_holding_latch(pc_high_holding_latch), .stack_top(stack_top),
        .prescaler_on_timer(prescaler_on_timer), .file_raddr(file_raddr),
        .nop_cycle(nop_cycle), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .w_reg(w_reg), .status_flags(status_flags), .pc(pc),
        .stack_push(stack_push), .stack_wdata(stack_wdata), .stack_pop(stack_pop),
        .interrupt_enable_set(interrupt_enable_set), .prescaler_clear(prescaler_clear),
        .watchdog_clear(watchdog_clear), .standby_enter(standby_enter));
    fbod_file_model u_file (.clk(clk), .file_raddr(file_raddr), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .file_rdata(file_rdata));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic issue(input logic [13:0] word);
        @(negedge clk);
        instr = word;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk(16'({pc, w_reg}), 16'h0000);
        chk(16'(status_flags), 16'h0018);
        resetn = 1'b1;
        for (int i = 0; i < 12; i++) begin
            issue(lw[i]);
            chk(16'({w_reg, 3'h0, status_flags}), 16'({ew[i], 3'h0, ef[i]}));
        end
        issue(14'h00A0);
        chk(16'({file_we, file_waddr, file_wdata}), 16'h A0FF);
        issue(14'h0FA0);
        chk(16'({nop_cycle, 2'h0, status_flags, file_wdata}), 16'h9800);
        issue(14'h0D04);
        chk(16'({file_we, status_flags, w_reg}), 16'h1828);
        issue(14'h0E04);
        chk(16'({status_flags, w_reg}), 16'h1841);
        issue(14'h1784);
        chk(16'({file_we, status_flags, file_wdata}), 16'h3894);
        issue(14'h1005);
        chk(16'(file_wdata), 16'h001C);
        issue(14'h0806);
        chk(16'({status_flags, w_reg}), 16'h18C3);
        issue(14'h0181);
        chk(16'(prescaler_clear), 16'h0000);
        prescaler_on_timer = 1'b1;
        issue(14'h0181);
        chk(16'({prescaler_clear, status_flags}), 16'h003C);
        issue(14'h3040);
        issue(14'h0082);
        chk(16'({file_we, nop_cycle, 1'b0, pc}), 16'h5540);
        issue(14'h0782);
        chk(16'({nop_cycle, 2'h0, pc}), 16'h9580);
        chk(16'(status_flags), 16'h0018);
        issue(14'h0802);
        chk(16'({pc[7:0], w_reg}), 16'h8180);
        issue(14'h2923);
        chk(16'({nop_cycle, 2'h0, pc}), 16'h9123);
        issue(14'h2055);
        chk(16'({stack_push, 2'h0, pc}), 16'h9055);
        chk(16'(stack_wdata), 16'h1124);
        issue(14'h0008);
        chk(16'({stack_pop, 2'h0, pc}), 16'h8ABC);
        issue(14'h3477);
        chk(16'({stack_pop, w_reg}), 16'h0177);
        issue(14'h0009);
        chk(16'({interrupt_enable_set, stack_pop}), 16'h0003);
        issue(14'h0063);
        chk(16'({standby_enter, nop_cycle, status_flags[4:3]}), 16'h000A);
        issue(14'h0064);
        chk(16'({watchdog_clear, nop_cycle, status_flags[4:3]}), 16'h000B);
        issue(14'h0183);
        chk(16'({file_we, status_flags[2:0]}), 16'h0004);
        test_done();
    end
endmodule
bind fbod_decoder fbod_decoder_monitor #(.PC_WIDTH(PC_WIDTH)) u_mon (.clk(clk), .resetn(resetn),
    .instr(instr), .instr_valid(instr_valid), .file_rdata(file_rdata),
    .pc_high_holding_latch(pc_high_holding_latch), .stack_top(stack_top),
    .prescaler_on_timer(prescaler_on_timer), .nop_cycle(nop_cycle), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata), .w_reg(w_reg),
    .status_flags(status_flags), .pc(pc), .stack_push(stack_push), .stack_pop(stack_pop),
    .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
    .standby_enter(standby_enter));
`default_nettype wire
